//--- tape_formatter_config_regs.sv
// Identification and tape-control registers of the tape formatter.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Type bit 15 always reads one.
// RULE2: Type bits 14=1, 13=0, 11=0.
// RULE3: Bit 12 set for seven-track slave.
// RULE4: Bit 10 set when slave powered, assigned.
// RULE5: Type field shows slave code or none.
// RULE6: Serial register shows four BCD digits.
// RULE7: Control bit 15 one while not transferring.
// RULE8: Frame status set on count write.
// RULE9: Space/write without frame status is rejected.
// RULE10: Written flag set by write, cleared by motion.
// RULE11: Written flag gates waiting for settle-down.
// RULE12: Host waits settle-down while flag set.
// RULE13: Abort bit stops transfer on errors.
// RULE14: Density codes select NRZI or PE.
// RULE15: Format codes select packing mode.
// RULE16: Bad format on transfer sets error.
// RULE17: NRZI parity even or odd by bit.
// RULE18: Even NRZI zero character becomes 020.
// RULE19: PE mode always uses odd parity.
// RULE20: Slave select picks the transport number.
// RULE21: Unused bits read zero, ignore writes.
module tape_formatter_config_regs (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Drive clear or bus initialise.
	input wire logic drive_clear,
	// Control bus register access.
	input wire tape_cfg_pkg::ctl_req_s ctl_req,
	output logic [15:0] ctl_rdata,
	// Selected slave information.
	input wire tape_cfg_pkg::slave_info_s slave,
	output logic [2:0] slave_number,
	// Data path and command events.
	input wire logic xfer_active,
	input wire logic frame_count_write,
	input wire logic frame_count_overflow,
	input wire logic cmd_go,
	input wire logic cmd_space_or_write,
	input wire logic cmd_data_xfer,
	input wire logic cmd_motion,
	input wire logic settle_down,
	input wire logic bus_parity_err,
	input wire logic crc_correct_err,
	input wire logic lrc_format_err,
	input wire logic vertical_parity_err,
	// Write character path.
	input wire logic [7:0] char_in,
	output logic [8:0] char_out,
	// Mode and result outputs.
	output logic pe_mode,
	output logic [1:0] format_mode,
	output logic nonexec_flag,
	output logic format_err,
	output logic xfer_abort,
	output logic wait_settle
);
	import tape_cfg_pkg::*;

	logic [10:0] set_r;
	logic fcs_r;
	logic written_r;
	logic [15:0] rdata_nxt;
	logic [8:0] char_nxt;

	logic abort_bit_r;
	wire [2:0] density_field;
	wire [3:0] format_field;
	wire even_parity_sel;
	wire abort_on_xfer_error;
	wire wr_settings;
	wire slave_present;
	wire is_pe;
	wire format_ok;
	wire any_err;
	wire odd_par;
	wire par_bit;
	wire zero_fix;
	wire [15:0] type_word;
	wire [15:0] tc_word;

	assign density_field = set_r[10:8];
	assign format_field = set_r[7:4];
	assign even_parity_sel = set_r[TC_EVPAR];
	assign abort_on_xfer_error = abort_bit_r;
	assign wr_settings = ctl_req.wr && ctl_req.addr == REG_SETTINGS;
	assign slave_present = slave.powered && slave.assigned; // RULE4
	// Only the top density bit picks the mode, so reserved codes 5 to 7 run as PE and codes 0 and 1 as NRZI.
	assign is_pe = density_field[2]; // RULE19
	assign format_ok = format_field == FORMAT_NORMAL ||
		format_field == FORMAT_CORE_DUMP || format_field == FORMAT_FIFTEEN;
	assign any_err = bus_parity_err | crc_correct_err | lrc_format_err |
		vertical_parity_err;
	assign odd_par = ~^char_in;
	assign par_bit = (is_pe || !even_parity_sel) ? odd_par : ~odd_par;
	assign zero_fix = !is_pe && even_parity_sel && char_in == 8'h00;
	assign type_word = {1'b1, 1'b1, 1'b0, slave_present &&
		slave.seven_track, 1'b0, slave_present, 1'b0,
		slave_present ? slave.type_code : TYPE_NONE};
	assign tc_word = {!xfer_active, fcs_r, written_r, abort_bit_r,
		1'b0, set_r[10:0] & 11'h7FF};

	function automatic logic [15:0] read_mux(input logic [4:0] a,
		input logic [15:0] t, input logic [15:0] s, input logic [15:0] c);
		case (a)
			REG_TYPE_INFO: read_mux = t;
			REG_SERIAL: read_mux = s;
			REG_SETTINGS: read_mux = c;
			default: read_mux = 16'h0000;
		endcase
	endfunction : read_mux

	assign rdata_nxt = read_mux(ctl_req.addr, type_word, slave.serial,
		tc_word); // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE21
	assign char_nxt = zero_fix ? {1'b1, 8'h10} : {par_bit, char_in}; // RULE17 RULE18 RULE19

	// Density, format, parity and slave select survive drive clear.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			set_r <= SETTINGS_RESET;
			abort_bit_r <= 1'b0;
		end else if (wr_settings) begin
			set_r <= ctl_req.wdata[10:0]; // RULE14 RULE15 RULE20
			abort_bit_r <= ctl_req.wdata[TC_ABORT];
		end
	end

	// Set wins over clear so a count write is never lost.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fcs_r <= 1'b0;
		end else if (frame_count_write) begin
			fcs_r <= 1'b1; // RULE8
		end else if (frame_count_overflow || drive_clear) begin
			fcs_r <= 1'b0; // RULE8
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			written_r <= 1'b0;
		end else if (wr_settings) begin
			written_r <= 1'b1; // RULE10
		end else if (cmd_go && cmd_motion) begin
			written_r <= 1'b0; // RULE10
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctl_rdata <= 16'h0000;
			char_out <= 9'h000;
			slave_number <= 3'h0;
			pe_mode <= 1'b0;
			format_mode <= 2'h0;
			nonexec_flag <= 1'b0;
			format_err <= 1'b0;
			xfer_abort <= 1'b0;
			wait_settle <= 1'b0;
		end else begin
			ctl_rdata <= rdata_nxt;
			char_out <= char_nxt;
			slave_number <= set_r[2:0];
			pe_mode <= density_field[2]; // RULE19
			format_mode <= format_field[1:0]; // RULE15
			nonexec_flag <= cmd_go && cmd_space_or_write && !fcs_r; // RULE9
			format_err <= cmd_go && cmd_data_xfer && !format_ok; // RULE16
			xfer_abort <= abort_on_xfer_error && xfer_active && any_err; // RULE13
			wait_settle <= written_r && settle_down; // RULE11
		end
	end

	AST_NO_SECTOR: assert property ( // RULE1
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_TYPE_INFO |=> ctl_rdata[DT_NO_SECTOR])
		else $error("type bit 15 not one");

	AST_FIXED: assert property ( // RULE2
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_TYPE_INFO |=> ctl_rdata[DT_TAPE] &&
		!ctl_rdata[DT_MOVING_HEAD] && !ctl_rdata[DT_DUAL_PORT])
		else $error("fixed type bits wrong");

	AST_SEVEN_TRACK: assert property ( // RULE3
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_TYPE_INFO |=> ctl_rdata[DT_SEVEN_TRACK] ==
		$past(slave_present && slave.seven_track))
		else $error("seven-track bit wrong");

	AST_PRESENT: assert property ( // RULE4
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_TYPE_INFO |=>
		ctl_rdata[DT_SLAVE_PRESENT] == $past(slave_present))
		else $error("slave present bit wrong");

	AST_TYPE_CODE: assert property ( // RULE5
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_TYPE_INFO |=> ctl_rdata[8:0] ==
		$past(slave_present ? slave.type_code : TYPE_NONE))
		else $error("type code wrong");

	AST_SERIAL: assert property ( // RULE6
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_SERIAL |=> ctl_rdata == $past(slave.serial))
		else $error("serial digits wrong");

	AST_IDLE: assert property ( // RULE7
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_SETTINGS |=>
		ctl_rdata[TC_IDLE] == !$past(xfer_active))
		else $error("idle bit wrong");

	AST_SPARE_TYPE: assert property ( // RULE21
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_TYPE_INFO |=> !ctl_rdata[9])
		else $error("unused type bit set");

	AST_SPARE_SETTINGS: assert property ( // RULE21
		@(posedge clk_sys) disable iff (!reset_n)
		ctl_req.addr == REG_SETTINGS |=> !ctl_rdata[11])
		else $error("unused control bit set");

	AST_FRAME_SET: assert property ( // RULE8
		@(posedge clk_sys) disable iff (!reset_n)
		frame_count_write |=> fcs_r)
		else $error("frame status not set");

	AST_FRAME_CLEAR: assert property ( // RULE8
		@(posedge clk_sys) disable iff (!reset_n)
		!frame_count_write && (frame_count_overflow || drive_clear) |=> !fcs_r)
		else $error("frame status not cleared");

	AST_NONEXEC: assert property ( // RULE9
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_go && cmd_space_or_write && !fcs_r |=> nonexec_flag)
		else $error("nonexec not flagged");

	AST_WRITTEN: assert property ( // RULE10
		@(posedge clk_sys) disable iff (!reset_n)
		wr_settings |=> written_r)
		else $error("written flag not set");

	AST_WRITTEN_CLEAR: assert property ( // RULE10
		@(posedge clk_sys) disable iff (!reset_n)
		!wr_settings && cmd_go && cmd_motion |=> !written_r)
		else $error("written flag not cleared");

	AST_SETTLE: assert property ( // RULE11
		@(posedge clk_sys) disable iff (!reset_n)
		written_r && settle_down |=> wait_settle)
		else $error("settle wait missed");

	AST_NO_SETTLE: assert property ( // RULE11
		@(posedge clk_sys) disable iff (!reset_n)
		!written_r |=> !wait_settle)
		else $error("settle wait without write");

	AST_ABORT: assert property ( // RULE13
		@(posedge clk_sys) disable iff (!reset_n)
		abort_bit_r && xfer_active && bus_parity_err |=> xfer_abort)
		else $error("no abort on error");

	AST_ABORT_ANY: assert property ( // RULE13
		@(posedge clk_sys) disable iff (!reset_n)
		abort_bit_r && xfer_active && any_err |=> xfer_abort)
		else $error("no abort on any error");

	AST_NO_ABORT: assert property ( // RULE13
		@(posedge clk_sys) disable iff (!reset_n)
		!abort_bit_r |=> !xfer_abort)
		else $error("abort while disabled");

	AST_DENSITY: assert property ( // RULE14
		@(posedge clk_sys) disable iff (!reset_n)
		wr_settings |=> density_field == $past(ctl_req.wdata[10:8]))
		else $error("density not stored");

	AST_KEEP: assert property ( // RULE14 RULE20
		@(posedge clk_sys) disable iff (!reset_n)
		drive_clear && !wr_settings |=> $stable(set_r))
		else $error("settings changed by clear");

	AST_FORMAT_MODE: assert property ( // RULE15
		@(posedge clk_sys) disable iff (!reset_n)
		!wr_settings |=> format_mode == format_field[1:0])
		else $error("format mode wrong");

	AST_BAD_FORMAT: assert property ( // RULE16
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_go && cmd_data_xfer && format_field == 4'h0 |=> format_err)
		else $error("format error missed");

	AST_GOOD_FORMAT: assert property ( // RULE16
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_go && cmd_data_xfer && format_ok |=> !format_err)
		else $error("format error on good code");

	AST_PARITY: assert property ( // RULE17
		@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> (^char_out) == $past(is_pe || !even_parity_sel))
		else $error("character parity wrong");

	AST_ZERO: assert property ( // RULE18
		@(posedge clk_sys) disable iff (!reset_n)
		!is_pe && even_parity_sel && char_in == 8'h00 |=> char_out == 9'h110)
		else $error("zero char not fixed");

	AST_PE_MODE: assert property ( // RULE19
		@(posedge clk_sys) disable iff (!reset_n)
		!wr_settings |=> pe_mode == density_field[2])
		else $error("pe mode wrong");

	AST_PE_ODD: assert property ( // RULE19
		@(posedge clk_sys) disable iff (!reset_n)
		is_pe |=> ^char_out)
		else $error("pe parity not odd");

	AST_SELECT: assert property ( // RULE20
		@(posedge clk_sys) disable iff (!reset_n)
		!wr_settings |=> slave_number == set_r[2:0])
		else $error("slave number wrong");

	COV_WR: cover property (@(posedge clk_sys) wr_settings);
	COV_NONEXEC: cover property (@(posedge clk_sys) nonexec_flag);
	COV_ABORT: cover property (@(posedge clk_sys) xfer_abort);
	COV_FORMAT_ERR: cover property (@(posedge clk_sys) format_err);
	COV_WAIT: cover property (@(posedge clk_sys) wait_settle);
endmodule : tape_formatter_config_regs

//--- tape_cfg_pkg.sv
// Package of offsets, field positions and codes for the tape formatter registers.
package tape_cfg_pkg;
	// Register indices on the control bus (five-bit drive register address).
	localparam logic [4:0] REG_TYPE_INFO = 5'h06;
	localparam logic [4:0] REG_SERIAL = 5'h08;
	localparam logic [4:0] REG_SETTINGS = 5'h09;
	// Drive-type register bit positions.
	localparam int DT_NO_SECTOR = 15;
	localparam int DT_TAPE = 14;
	localparam int DT_MOVING_HEAD = 13;
	localparam int DT_SEVEN_TRACK = 12;
	localparam int DT_DUAL_PORT = 11;
	localparam int DT_SLAVE_PRESENT = 10;
	// Type code shown when no slave holds the select code.
	// The value is arbitrary.
	localparam logic [8:0] TYPE_NONE = 9'h0F5;
	// Tape-control register bit positions.
	localparam int TC_IDLE = 15;
	localparam int TC_FRAME = 14;
	localparam int TC_WRITTEN = 13;
	localparam int TC_ABORT = 12;
	localparam int TC_DEN_LSB = 8;
	localparam int TC_FMT_LSB = 4;
	localparam int TC_EVPAR = 3;
	// Writable mask of the tape-control register.
	localparam logic [15:0] TC_WMASK = 16'h17FF;
	// Density and format codes.
	localparam logic [2:0] DEN_NRZ_A = 3'h2;
	localparam logic [2:0] DEN_NRZ_B = 3'h3;
	localparam logic [2:0] DEN_PE = 3'h4;
	localparam logic [3:0] FORMAT_NORMAL = 4'hC;
	localparam logic [3:0] FORMAT_CORE_DUMP = 4'hD;
	localparam logic [3:0] FORMAT_FIFTEEN = 4'hE;
	// Character bit inverted to avoid an all-zero even-parity character.
	localparam int CHAR_FIX_BIT = 4;
	// Reset value of the writable settings fields.
	localparam logic [10:0] SETTINGS_RESET = 11'h000;

	typedef struct packed {
		logic wr;
		logic [4:0] addr;
		logic [15:0] wdata;
	} ctl_req_s;

	typedef struct packed {
		logic powered;
		logic assigned;
		logic seven_track;
		logic [8:0] type_code;
		logic [15:0] serial;
	} slave_info_s;
endpackage : tape_cfg_pkg

//--- tape_slave_model.sv
// Slave transport model answering the select code.
`timescale 1ns/1ps
module tape_slave_model
	import tape_cfg_pkg::*;
#(
	// Arbitrary type code of a present unit.
	parameter logic [8:0] TYPE_A = 9'h0A7
) (
	// Select code and status lines.
	input wire logic [2:0] slave_number,
	output tape_cfg_pkg::slave_info_s slave
);
	// Only units 0 and 1 exist; absent units drive junk on purpose.
	wire logic here = slave_number < 3'h2;
	assign slave = '{here, here, slave_number == 3'h1,
		here ? TYPE_A : 9'h1FF, {13'h0806, slave_number}};
endmodule : tape_slave_model

//--- test_tape_formatter_config_regs.sv
// Self-checking bench for the tape formatter registers.
`timescale 1ns/1ps
module test_tape_formatter_config_regs;
	import tape_cfg_pkg::*;
	logic clk_sys = 0, reset_n = 0, xfer_active = 0;
	logic cmd_space_or_write = 0, ev_p;
	logic cmd_data_xfer = 0, settle_down = 0;
	logic [4:0] ev = '0;
	logic [3:0] errs = '0;
	logic [2:0] den;
	logic [7:0] char_in = '0, c;
	ctl_req_s ctl_req = '0;
	slave_info_s slave;
	logic [15:0] ctl_rdata;
	logic [8:0] char_out;
	logic [2:0] slave_number;
	logic [1:0] format_mode;
	logic pe_mode, nonexec_flag, format_err, xfer_abort, wait_settle;
	logic [16:0] exp_q[$];
	int err_count = 0, n_tests = 0, cyc = 0, seed = 63227;
	tape_formatter_config_regs uut (.clk_sys(clk_sys), .reset_n(reset_n),
		.drive_clear(ev[0]), .ctl_req(ctl_req), .ctl_rdata(ctl_rdata),
		.slave(slave), .slave_number(slave_number),
		.xfer_active(xfer_active), .frame_count_write(ev[1]),
		.frame_count_overflow(ev[2]), .cmd_go(ev[4]),
		.cmd_space_or_write(cmd_space_or_write),
		.cmd_data_xfer(cmd_data_xfer), .cmd_motion(ev[3]),
		.settle_down(settle_down), .bus_parity_err(errs[0]),
		.crc_correct_err(errs[1]), .lrc_format_err(errs[2]),
		.vertical_parity_err(errs[3]), .char_in(char_in),
		.char_out(char_out), .pe_mode(pe_mode),
		.format_mode(format_mode), .nonexec_flag(nonexec_flag),
		.format_err(format_err), .xfer_abort(xfer_abort),
		.wait_settle(wait_settle));
	tape_slave_model partner (.slave_number(slave_number), .slave(slave));
	always #2.5 clk_sys = ~clk_sys;
	task automatic check(string nm, logic [15:0] s, logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic rd(logic [4:0] a, logic [15:0] e);
		@(posedge clk_sys);
		ctl_req <= '{1'b0, a, 16'h0000};
		@(posedge clk_sys);
		exp_q.push_back({1'b0, e});
	endtask : rd
	task automatic wr(logic [15:0] d);
		@(posedge clk_sys);
		ctl_req <= '{1'b1, REG_SETTINGS, d};
		@(posedge clk_sys);
		ctl_req.wr <= 1'b0;
	endtask : wr
	task automatic pulse(logic [4:0] m);
		@(posedge clk_sys);
		ev <= m;
		@(posedge clk_sys);
		ev <= '0;
	endtask : pulse
	function automatic logic [8:0] xc(logic [7:0] v, logic e, logic p);
		logic [7:0] d;
		d = (e && !p && v == 8'h00) ? 8'h10 : v;
		return {(e && !p) ? ^d : ~^d, d};
	endfunction : xc
	task automatic ch(logic [7:0] v);
		@(posedge clk_sys);
		char_in <= v;
		errs <= $random(seed);
		@(posedge clk_sys);
		exp_q.push_back({1'b1, 7'h00, xc(v, ev_p, den[2])});
	endtask : ch
	// Results are compared where they settle, away from the sampling edge.
	always @(negedge clk_sys) begin
		if (exp_q.size() > 0) begin
			if (exp_q[0][16])
				check("char", {7'h00, char_out}, exp_q[0][15:0]);
			else
				check("reg", ctl_rdata, exp_q[0][15:0]);
			void'(exp_q.pop_front());
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(REG_SETTINGS, 16'h8000);
		rd(5'h1F, 16'h0000);
		rd(REG_SERIAL, 16'h4030);
		wr(16'hFFFF);
		rd(REG_SETTINGS, 16'hB7FF);
		for (int u = 0; u < 8; u++) begin
			wr({8'h04, 5'h18, u[2:0]});
			rd(REG_TYPE_INFO, {3'h6, u == 1, 1'b0, u < 2, 1'b0,
				u < 2 ? 9'h0A7 : TYPE_NONE});
		end
		$display("type tests done");
		wr(16'h0448);
		pulse(5'h02);
		rd(REG_SETTINGS, 16'hE448);
		pulse(5'h18);
		rd(REG_SETTINGS, 16'hC448);
		pulse(5'h04);
		rd(REG_SETTINGS, 16'h8448);
		pulse(5'h02);
		pulse(5'h01);
		xfer_active <= 1'b1;
		rd(REG_SETTINGS, 16'h0448);
		xfer_active <= 1'b0;
		cmd_space_or_write <= 1'b1;
		pulse(5'h10);
		@(negedge clk_sys) check("nonexec", nonexec_flag, 1'b1);
		@(posedge clk_sys);
		cmd_space_or_write <= 1'b0;
		wr(16'h14D8);
		cmd_data_xfer <= 1'b1;
		xfer_active <= 1'b1;
		settle_down <= 1'b1;
		errs <= 4'h2;
		@(posedge clk_sys);
		@(negedge clk_sys) check("abort", xfer_abort, 1'b1);
		check("settle", wait_settle, 1'b1);
		check("fmode", format_mode, 2'h1);
		pulse(5'h10);
		@(negedge clk_sys) check("fmt ok", format_err, 1'b0);
		@(posedge clk_sys);
		settle_down <= 1'b0;
		xfer_active <= 1'b0;
		errs <= 4'h0;
		wr(16'h0400);
		pulse(5'h10);
		@(negedge clk_sys) check("fmt err", format_err, 1'b1);
		@(posedge clk_sys);
		cmd_data_xfer <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			den = 3'h2 + 3'(i / 2);
			ev_p = i[0];
			wr({5'h00, den, FORMAT_NORMAL, ev_p, 3'h0});
			@(posedge clk_sys);
			@(negedge clk_sys) check("pe", pe_mode, den == DEN_PE);
			ch(8'h00);
			c = $random(seed);
			ch(c);
		end
		$display("control tests done");
		repeat (2) @(posedge clk_sys);
		print_verdict();
	end
endmodule : test_tape_formatter_config_regs
